// >>> dv/css_checker.sv
// port checker for the start-up sequencer
// assumes the bind below onto css_sequencer
`timescale 1ns/1ns
module css_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] clock_source_select_fuses,
	input wire logic use_default_fuses,
	input wire logic wake_request,
	input wire logic osc_tick,
	input wire logic internal_reset,
	input wire logic sys_clk_tick,
	input wire css_pkg::css_src_t clock_source,
	input wire logic [1:0] crystal_range,
	input wire logic config_invalid
);
	import css_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire logic [3:0] sel = clock_source_select_fuses;
	sequence s_up; !rst ##1 !use_default_fuses; endsequence
	property p_rst; disable iff (1'b0) rst |=> internal_reset; endproperty
	property p_inv; config_invalid |-> internal_reset; endproperty
	property p_rsvd; s_up ##0 sel == 4'h1 |-> config_invalid; endproperty
	property p_cal;
		!rst ##1 (use_default_fuses || sel == 4'h2)
			|-> clock_source == CSS_SRC_CAL_RC;
	endproperty
	property p_lp;
		s_up ##0 sel[3] |-> clock_source == CSS_SRC_LP_XTAL
			&& crystal_range == sel[2:1];
	endproperty
	property p_fall; $fell(internal_reset) |-> $past(osc_tick); endproperty
	property p_rise;
		$rose(internal_reset) |-> $past(rst) || $past(wake_request);
	endproperty
	property p_quiet; internal_reset |-> !sys_clk_tick; endproperty
	property p_div; sys_clk_tick |-> $past(osc_tick); endproperty
	a_rst: assert property (p_rst) else $error("reset not held");
	a_inv: assert property (p_inv) else $error("bad code ran");
	a_rsvd: assert property (p_rsvd) else $error("no invalid");
	a_cal: assert property (p_cal) else $error("not cal rc");
	a_lp: assert property (p_lp) else $error("bad lp decode");
	a_fall: assert property (p_fall) else $error("early run");
	a_rise: assert property (p_rise) else $error("stray reset");
	a_quiet: assert property (p_quiet) else $error("tick in rst");
	a_div: assert property (p_div) else $error("stray tick");
	c_run: cover property ($fell(internal_reset));
	c_wake: cover property (wake_request ##1 internal_reset);
	c_bad: cover property (config_invalid);
endmodule // css_checker
bind css_sequencer css_checker u_chk (.ref_clk(ref_clk), .rst(rst),
	.clock_source_select_fuses(clock_source_select_fuses),
	.use_default_fuses(use_default_fuses), .wake_request(wake_request),
	.osc_tick(osc_tick), .internal_reset(internal_reset),
	.sys_clk_tick(sys_clk_tick), .clock_source(clock_source),
	.crystal_range(crystal_range), .config_invalid(config_invalid));

// >>> dv/css_fuse_prog.sv
// fuse programmer model: stores the fuse bits seen by the sequencer
// assumes the bench names the bits it wants programmed
`timescale 1ns/1ns
module css_fuse_prog (
	input wire logic [3:0] prog_sel,
	input wire logic [1:0] prog_sut,
	input wire logic prog_div,
	output logic [3:0] clock_source_select_fuses,
	output logic [1:0] startup_time_fuses,
	output logic divide_by_eight_fuse
);
	// a programmed bit is stored as zero
	assign clock_source_select_fuses = ~prog_sel;
	assign startup_time_fuses = ~prog_sut;
	assign divide_by_eight_fuse = ~prog_div;
endmodule // css_fuse_prog

// >>> dv/tb.sv
// bench: fuse settings and tick trains against the sequencer
// assumes ticks are counted on the bench side only
`timescale 1ns/1ns
module tb;
	import css_pkg::*;
	logic ref_clk=0, rst=1, dflt=0, wake=0, wt=0, ot=0, pd=0;
	logic [3:0] ps=0, sel;
	logic [1:0] pu=0, sut, rng;
	logic div, irst, sct, inv;
	css_src_t src;
	int error_cnt=0, n_tests=0, sc=0;
	css_fuse_prog u_fp (.prog_sel(ps), .prog_sut(pu), .prog_div(pd),
		.clock_source_select_fuses(sel), .startup_time_fuses(sut),
		.divide_by_eight_fuse(div));
	css_sequencer u_dut (.ref_clk(ref_clk), .rst(rst),
		.clock_source_select_fuses(sel), .startup_time_fuses(sut),
		.divide_by_eight_fuse(div), .use_default_fuses(dflt),
		.wake_request(wake), .wdt_tick(wt), .osc_tick(ot),
		.internal_reset(irst), .sys_clk_tick(sct), .clock_source(src),
		.crystal_range(rng), .config_invalid(inv));
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (sct === 1'b1) sc++;
	task chk(input string s, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s exp %0h got %0h", s, e, g);
		end
	endtask
	task tk(input logic w);
		@(posedge ref_clk);
		if (w) wt <= 1; else ot <= 1;
		@(posedge ref_clk);
		wt <= 0;
		ot <= 0;
		@(negedge ref_clk);
	endtask
	task boot(input logic [3:0] s, input logic [1:0] u, input logic [1:0] d,
		input int w);
		@(posedge ref_clk);
		rst <= 1;
		ps <= ~s;
		pu <= ~u;
		dflt <= d[0];
		pd <= d[1];
		repeat (2) @(posedge ref_clk);
		rst <= 0;
		@(posedge ref_clk);
		repeat (w) tk(1);
		@(negedge ref_clk);
		chk("hold", 1, irst);
	endtask
	// reserved codes must outlast the limit, so stop two ticks past it
	task run(input int g, input logic bad);
		int n;
		n = 0;
		while (irst !== 1'b0 && n < g + 2) begin
			tk(0);
			n++;
		end
		chk("osc", 16'(bad ? g + 2 : g), 16'(n));
		chk("inv", bad, inv);
		$display("test done %0d", g);
	endtask
	// tick counter runs free; only its growth over the window counts
	task divc(input int e);
		int s0;
		s0 = sc;
		repeat (16) tk(0);
		@(negedge ref_clk);
		chk("div", 16'(e), 16'(sc - s0));
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge ref_clk);
		error_cnt++;
		end_of_test;
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		boot(4'h0, 2'h0, 2'h1, 8192);
		run(6, 0);
		chk("src", CSS_SRC_CAL_RC, src);
		divc(2);
		boot(4'h0, 2'h0, 2'h0, 0);
		run(6, 0);
		chk("src", CSS_SRC_EXT, src);
		divc(16);
		boot(4'h3, 2'h1, 2'h2, 512);
		run(6, 0);
		chk("src", CSS_SRC_RC128, src);
		divc(2);
		boot(4'ha, 2'h0, 2'h0, 512);
		run(272, 0);
		chk("rng", 1, rng);
		chk("src", CSS_SRC_LP_XTAL, src);
		@(posedge ref_clk);
		wake <= 1;
		@(posedge ref_clk);
		wake <= 0;
		@(negedge ref_clk);
		chk("wake", 1, irst);
		run(258, 0);
		boot(4'he, 2'h2, 2'h0, 0);
		run(1038, 0);
		chk("rng", 3, rng);
		chk("src", CSS_SRC_LP_XTAL, src);
		boot(4'hf, 2'h1, 2'h0, 0);
		run(16398, 0);
		boot(4'h6, 2'h2, 2'h0, 0);
		run(1038, 0);
		chk("src", CSS_SRC_FS_XTAL, src);
		boot(4'h4, 2'h0, 2'h0, 0);
		run(1038, 0);
		chk("src", CSS_SRC_LF_XTAL, src);
		boot(4'h1, 2'h0, 2'h0, 0);
		run(20, 1);
		boot(4'h4, 2'h3, 2'h0, 0);
		run(20, 1);
		end_of_test;
	end
endmodule // tb

// >>> hw/css_cfg.svh
// constants for the clock source start-up sequencer
// assumes inclusion by the design file only; the package does not include it
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH
`define CSS_SEL_EXT 4'h0
`define CSS_SEL_RSVD 4'h1
`define CSS_SEL_CALRC 4'h2
`define CSS_SEL_RC128 4'h3
`define CSS_DEF_SEL 4'h2
`define CSS_DEF_SUT 2'h2
`define CSS_DEF_DIV8 1'b0
`define CSS_TOUT_0 14'd0
`define CSS_TOUT_4MS 14'd512
`define CSS_TOUT_65MS 14'd8192
`define CSS_SU_EXT 16'd6
`define CSS_SU_258 16'd258
`define CSS_SU_1K 16'd1024
`define CSS_SU_16K 16'd16384
`define CSS_SU_32K 16'd32768
`define CSS_SU_EXTRA 16'd14
`define CSS_DIV 4'd8
`endif

// >>> hw/css_pkg.sv
// types for the clock source start-up sequencer
// assumes no include file; css_cfg.svh is not used here
package css_pkg;
	typedef enum logic [2:0] {
		CSS_SRC_LP_XTAL,
		CSS_SRC_FS_XTAL,
		CSS_SRC_LF_XTAL,
		CSS_SRC_RC128,
		CSS_SRC_CAL_RC,
		CSS_SRC_EXT,
		CSS_SRC_BAD
	} css_src_t;
	typedef enum logic [2:0] {
		CSS_ST_IDLE,
		CSS_ST_TOUT,
		CSS_ST_OSC,
		CSS_ST_RUN,
		CSS_ST_STUCK
	} css_state_t;
endpackage

// >>> hw/css_sequencer.sv
// clock source select decode and reset start-up sequencer
// assumes fuses are stable, wdt_tick and osc_tick are one-cycle pulses
// synchronous to ref_clk, one per watchdog / oscillator cycle
`timescale 1ns/1ns
`include "css_cfg.svh"
module css_sequencer (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] clock_source_select_fuses,
	input wire logic [1:0] startup_time_fuses,
	input wire logic divide_by_eight_fuse,
	input wire logic use_default_fuses,
	input wire logic wake_request,
	input wire logic wdt_tick,
	input wire logic osc_tick,
	output logic internal_reset,
	output logic sys_clk_tick,
	output css_pkg::css_src_t clock_source,
	output logic [1:0] crystal_range,
	output logic config_invalid
);
	import css_pkg::*;

	logic [3:0] sel;
	logic [1:0] sut;
	logic div8_on;
	css_src_t src;
	logic [13:0] tout_len;
	logic [15:0] su_len;
	logic bad;
	logic startup_select_low_bit;
	logic [2:0] crystal_range_select_bits;

	// factory default overrides the fuse inputs
	always_comb begin
		sel = use_default_fuses ? `CSS_DEF_SEL : clock_source_select_fuses;
		sut = use_default_fuses ? `CSS_DEF_SUT : startup_time_fuses;
		div8_on = (use_default_fuses ? `CSS_DEF_DIV8
			: divide_by_eight_fuse) == 1'b0;
		startup_select_low_bit = sel[0];
		crystal_range_select_bits = sel[3:1];
	end

	// source decode and start-up table
	always_comb begin
		src = CSS_SRC_BAD;
		tout_len = `CSS_TOUT_0;
		su_len = `CSS_SU_EXT;
		bad = 1'b0;
		if (sel[3]) begin
			src = CSS_SRC_LP_XTAL;
		end else if (sel[3:1] == 3'h3) begin
			src = CSS_SRC_FS_XTAL;
		end else if (sel[3:1] == 3'h2) begin
			src = CSS_SRC_LF_XTAL;
		end else if (sel == `CSS_SEL_RC128) begin
			src = CSS_SRC_RC128;
		end else if (sel == `CSS_SEL_CALRC) begin
			src = CSS_SRC_CAL_RC;
		end else if (sel == `CSS_SEL_EXT) begin
			src = CSS_SRC_EXT;
		end else begin
			bad = 1'b1;
		end
		case (src)
		CSS_SRC_LP_XTAL, CSS_SRC_FS_XTAL: begin
			// LP and FS crystals share one table; LF has its own
			case ({startup_select_low_bit, sut})
			3'b000: begin
				su_len = `CSS_SU_258;
				tout_len = `CSS_TOUT_4MS;
			end
			3'b001: begin
				su_len = `CSS_SU_258;
				tout_len = `CSS_TOUT_65MS;
			end
			3'b010: begin
				su_len = `CSS_SU_1K;
				tout_len = `CSS_TOUT_0;
			end
			3'b011: begin
				su_len = `CSS_SU_1K;
				tout_len = `CSS_TOUT_4MS;
			end
			3'b100: begin
				su_len = `CSS_SU_1K;
				tout_len = `CSS_TOUT_65MS;
			end
			3'b101: begin
				su_len = `CSS_SU_16K;
				tout_len = `CSS_TOUT_0;
			end
			3'b110: begin
				su_len = `CSS_SU_16K;
				tout_len = `CSS_TOUT_4MS;
			end
			default: begin
				su_len = `CSS_SU_16K;
				tout_len = `CSS_TOUT_65MS;
			end
			endcase
		end
		CSS_SRC_LF_XTAL: begin
			su_len = startup_select_low_bit ? `CSS_SU_32K : `CSS_SU_1K;
			case (sut)
			2'h0: tout_len = `CSS_TOUT_0;
			2'h1: tout_len = `CSS_TOUT_4MS;
			2'h2: tout_len = `CSS_TOUT_65MS;
			default: bad = 1'b1;
			endcase
		end
		CSS_SRC_BAD: bad = 1'b1;
		default: begin
			// rc and external: 6 clocks, time-out from sut
			su_len = `CSS_SU_EXT;
			case (sut)
			2'h0: tout_len = `CSS_TOUT_0;
			2'h1: tout_len = `CSS_TOUT_4MS;
			2'h2: tout_len = `CSS_TOUT_65MS;
			default: bad = 1'b1;
			endcase
		end
		endcase
	end

	css_state_t state, next_state;
	logic [13:0] tout_cnt, next_tout_cnt;
	logic [15:0] osc_cnt, next_osc_cnt;
	logic [15:0] osc_goal, next_osc_goal;
	logic [2:0] div_cnt, next_div_cnt;
	logic next_internal_reset;
	logic next_sys_clk_tick;
	logic next_config_invalid;
	css_src_t next_clock_source;
	logic [1:0] next_crystal_range;

	always_comb begin
		next_state = state;
		next_tout_cnt = tout_cnt;
		next_osc_cnt = osc_cnt;
		next_osc_goal = osc_goal;
		next_div_cnt = div_cnt;
		next_internal_reset = 1'b1;
		next_sys_clk_tick = 1'b0;
		next_config_invalid = bad;
		next_clock_source = src;
		// range 100..111 maps to 0..3
		next_crystal_range = (src == CSS_SRC_LP_XTAL)
			? crystal_range_select_bits[1:0] : 2'h0;
		case (state)
		CSS_ST_IDLE: begin
			next_tout_cnt = 14'd0;
			next_osc_cnt = 16'd0;
			// reset path adds 14 clocks on crystals, as tabled
			next_osc_goal = su_len + ((src == CSS_SRC_LP_XTAL
				|| src == CSS_SRC_FS_XTAL || src == CSS_SRC_LF_XTAL)
				? `CSS_SU_EXTRA : 16'd0);
			if (bad)
				next_state = CSS_ST_STUCK;
			else if (tout_len == `CSS_TOUT_0)
				next_state = CSS_ST_OSC;
			else
				next_state = CSS_ST_TOUT;
		end
		CSS_ST_TOUT: begin
			if (wdt_tick) begin
				next_tout_cnt = tout_cnt + 14'd1;
				if (tout_cnt + 14'd1 == tout_len)
					next_state = CSS_ST_OSC;
			end
		end
		CSS_ST_OSC: begin
			if (osc_tick) begin
				next_osc_cnt = osc_cnt + 16'd1;
				if (osc_cnt + 16'd1 == osc_goal) begin
					next_state = CSS_ST_RUN;
					next_internal_reset = 1'b0;
					next_div_cnt = 3'd0;
				end
			end
		end
		CSS_ST_RUN: begin
			next_internal_reset = 1'b0;
			if (wake_request) begin
				// wake skips the watchdog time-out
				next_state = CSS_ST_OSC;
				next_osc_cnt = 16'd0;
				next_osc_goal = su_len;
				next_internal_reset = 1'b1;
			end else if (osc_tick) begin
				if (!div8_on) begin
					next_sys_clk_tick = 1'b1;
				end else begin
					next_div_cnt = div_cnt + 3'd1;
					next_sys_clk_tick = div_cnt == 3'(`CSS_DIV - 4'd1);
				end
			end
		end
		default: next_state = CSS_ST_STUCK;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state <= CSS_ST_IDLE;
			tout_cnt <= 14'd0;
			osc_cnt <= 16'd0;
			osc_goal <= 16'd0;
			div_cnt <= 3'd0;
			internal_reset <= 1'b1;
			sys_clk_tick <= 1'b0;
			config_invalid <= 1'b0;
			clock_source <= CSS_SRC_CAL_RC;
			crystal_range <= 2'h0;
		end else begin
			state <= next_state;
			tout_cnt <= next_tout_cnt;
			osc_cnt <= next_osc_cnt;
			osc_goal <= next_osc_goal;
			div_cnt <= next_div_cnt;
			internal_reset <= next_internal_reset;
			sys_clk_tick <= next_sys_clk_tick;
			config_invalid <= next_config_invalid;
			clock_source <= next_clock_source;
			crystal_range <= next_crystal_range;
		end
	end
endmodule // css_sequencer
